// ---- src/eeprom_pkg.sv ----
package eeprom_pkg;
  // decoded instruction
  typedef enum logic [2:0] {
    cmd_none, read_cmd, enable_writes_cmd, write_cmd, fill_all_cmd,
    disable_writes_cmd, erase_cmd, clear_all_cmd
  } cmd_e;
  // field widths
  localparam int OPCODE_W = 2;
  localparam int ADDR_W = 6;
  localparam int WORD_ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int WORDS = 16;
  localparam int FRAME_W = 1 + OPCODE_W + ADDR_W + DATA_W;
  // last bit index of each field, as the phase counter sees it
  localparam logic [3:0] OPCODE_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h5;
  localparam logic [3:0] DATA_LAST = 4'hf;
  // opcode and subcode encodings
  localparam logic [1:0] OP_EXTENDED = 2'h0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  // erased word and frame lengths
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [4:0] SHORT_FRAME_LAST = 5'h08;
  localparam logic [4:0] LONG_FRAME_LAST = 5'h18;
  // timing
  localparam int CLOCK_NS = 100;
  localparam int PROGRAM_CYCLE_TIME_NS = 15000000;
  localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_NS / CLOCK_NS;
  localparam int DESELECT_INTERVAL_NS = 1000;
  localparam int DESELECT_CYCLES =
    (DESELECT_INTERVAL_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int STATUS_SETTLE_CYCLES = 8;
  localparam int SHIFT_HALF_CYCLES = 5;
endpackage

// ---- src/eeprom_if.sv ----
`timescale 1ns/1ps
// four-wire serial link between master and memory
interface eeprom_if;
  logic shift_clock; // made by the master
  logic select; // high while a frame is open
  logic serial_in; // master to memory
  logic serial_out; // memory to master, valid when enabled
  logic serial_out_oe; // memory drives the output
  logic serial_line; // resolved output wire
  // weak pull-up when nobody drives the output
  assign serial_line = serial_out_oe ? serial_out : 1'b1;
  modport dev (
    input shift_clock,
    input select,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output shift_clock,
    output select,
    output serial_in,
    input serial_line
  );
endinterface

// ---- src/eeprom_device.sv ----
`timescale 1ns/1ps
// memory end: command shifter on the link clock,
// write-enable, programming timer and array on the local clock
module eeprom_device #(
  parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  output logic busy,
  eeprom_if.dev link
);
  localparam int TW = $clog2(PROGRAM_CYCLES + 1);

  // frame phase on the shift clock
  typedef enum {
    ph_start, ph_opcode, ph_address, ph_data, ph_read, ph_done
  } phase_e;

  phase_e phase_r; // current field
  logic [3:0] cnt_r; // bit within field
  logic [15:0] sh_r; // incoming bit history
  logic [16:0] out_sh_r; // dummy bit plus read word
  logic [7:0] head; // opcode and address incl. current bit
  logic [15:0] data_word; // data incl. current bit
  eeprom_pkg::cmd_e head_cmd; // decode of head
  logic [15:0] rd_word; // array word at head address
  logic hdr_fire; // last address bit now
  logic done_fire; // last bit of a non-read frame now
  logic start_fire; // start bit now

  // hand-over words, stable from frame end to deselect
  eeprom_pkg::cmd_e cmd_r;
  logic [3:0] addr_r;
  logic [15:0] data_r;
  logic done_tgl_r; // flips once per finished non-read frame
  logic clear_tgl_r; // flips once per start bit

  // local clock domain
  logic sel_s1, sel_s2, sel_d; // select synchroniser and delay
  logic done_s1, done_s2, done_seen_r;
  logic clr_s1, clr_s2, clr_seen_r;
  logic sel_fall; // deselect seen locally
  logic new_cmd; // a finished frame was closed
  logic prog_start; // programming cycle begins
  logic prog_end; // programming cycle finished
  logic wen_r; // write-enable state
  logic busy_r; // programming in progress
  logic status_r; // output shows ready/busy
  logic [TW-1:0] timer_r; // cycles left in programming
  eeprom_pkg::cmd_e job_r; // command being programmed
  logic [3:0] job_addr_r;
  logic [15:0] job_data_r;
  logic [15:0] mem_r [eeprom_pkg::WORDS]; // the array

  // current bit joined to what is already shifted in;
  // the start bit has dropped out above bit 7 by now
  assign head = {sh_r[6:0], link.serial_in};
  assign data_word = {sh_r[14:0], link.serial_in};
  // array is only changed while busy, when reads are masked by status,
  // so the link side may read it without a crossing
  assign rd_word = mem_r[head[3:0]];

  // instruction decode from opcode and upper address bits
  always_comb begin
    head_cmd = eeprom_pkg::cmd_none;
    unique case (head[7:6])
      eeprom_pkg::OP_READ: head_cmd = eeprom_pkg::read_cmd;
      eeprom_pkg::OP_WRITE: head_cmd = eeprom_pkg::write_cmd;
      eeprom_pkg::OP_ERASE: head_cmd = eeprom_pkg::erase_cmd;
      eeprom_pkg::OP_EXTENDED: begin
        unique case (head[5:4])
          eeprom_pkg::SUB_ENABLE: head_cmd = eeprom_pkg::enable_writes_cmd;
          eeprom_pkg::SUB_FILL: head_cmd = eeprom_pkg::fill_all_cmd;
          eeprom_pkg::SUB_DISABLE: head_cmd = eeprom_pkg::disable_writes_cmd;
          eeprom_pkg::SUB_CLEAR: head_cmd = eeprom_pkg::clear_all_cmd;
        endcase
      end
    endcase
  end

  // event strobes on the shift clock
  assign start_fire = (phase_r == ph_start) && link.serial_in;
  assign hdr_fire = (phase_r == ph_address) &&
                    (cnt_r == eeprom_pkg::ADDR_LAST);
  assign done_fire = (hdr_fire && head_cmd != eeprom_pkg::read_cmd &&
                      head_cmd != eeprom_pkg::write_cmd &&
                      head_cmd != eeprom_pkg::fill_all_cmd) ||
                     (phase_r == ph_data &&
                      cnt_r == eeprom_pkg::DATA_LAST);

  // frame parser; deselect clears it at once, with no edge needed
  // deselect resets frame
  always_ff @(posedge link.shift_clock or negedge link.select) begin
    if (!link.select) begin
      phase_r <= ph_start;
      cnt_r <= 4'h0;
      sh_r <= 16'h0000;
      out_sh_r <= 17'h00000;
    end else begin
      sh_r <= {sh_r[14:0], link.serial_in};
      unique case (phase_r)
        ph_start: begin
          if (link.serial_in) begin
            phase_r <= ph_opcode;
            cnt_r <= 4'h0;
          end
        end
        ph_opcode: begin
          if (cnt_r == eeprom_pkg::OPCODE_LAST) begin
            phase_r <= ph_address;
            cnt_r <= 4'h0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ph_address: begin
          if (cnt_r == eeprom_pkg::ADDR_LAST) begin
            cnt_r <= 4'h0;
            if (head_cmd == eeprom_pkg::read_cmd) begin
              out_sh_r <= {1'b0, rd_word};
              phase_r <= ph_read;
            end else if (head_cmd == eeprom_pkg::write_cmd ||
                         head_cmd == eeprom_pkg::fill_all_cmd) begin
              phase_r <= ph_data;
            end else begin
              phase_r <= ph_done;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ph_data: begin
          if (cnt_r == eeprom_pkg::DATA_LAST) begin
            phase_r <= ph_done;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ph_read: begin
          // next bit on each rising edge
          out_sh_r <= {out_sh_r[15:0], 1'b0};
        end
        ph_done: begin
          // extra clocks after a finished frame are ignored
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // hand-over words and toggles survive deselect
  always_ff @(posedge link.shift_clock or posedge rst) begin
    if (rst) begin
      cmd_r <= eeprom_pkg::cmd_none;
      addr_r <= 4'h0;
      data_r <= 16'h0000;
      done_tgl_r <= 1'b0;
      clear_tgl_r <= 1'b0;
    end else begin
      if (hdr_fire) begin
        cmd_r <= head_cmd;
        addr_r <= head[3:0];
      end
      if (phase_r == ph_data && cnt_r == eeprom_pkg::DATA_LAST) begin
        data_r <= data_word;
      end
      if (done_fire) begin
        done_tgl_r <= ~done_tgl_r;
      end
      if (start_fire) begin
        clear_tgl_r <= ~clear_tgl_r;
      end
    end
  end

  // two-stage synchronisers into the local clock
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sel_d <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
    end else begin
      sel_s1 <= link.select;
      sel_s2 <= sel_s1;
      sel_d <= sel_s2;
      done_s1 <= done_tgl_r;
      done_s2 <= done_s1;
      clr_s1 <= clear_tgl_r;
      clr_s2 <= clr_s1;
    end
  end

  // a frame counts only if it finished before deselect
  assign sel_fall = sel_d & ~sel_s2;
  assign new_cmd = sel_fall & (done_s2 != done_seen_r);

  // consumed-event trackers
  always_ff @(posedge clock) begin
    if (rst) begin
      done_seen_r <= 1'b0;
      clr_seen_r <= 1'b0;
    end else begin
      if (sel_fall) begin
        done_seen_r <= done_s2;
      end
      clr_seen_r <= clr_s2;
    end
  end

  // programming begins at deselect, never while busy
  assign prog_start = new_cmd & ~busy_r & wen_r &
                      (cmd_r == eeprom_pkg::write_cmd ||
                       cmd_r == eeprom_pkg::fill_all_cmd ||
                       cmd_r == eeprom_pkg::erase_cmd ||
                       cmd_r == eeprom_pkg::clear_all_cmd);
  assign prog_end = busy_r && (timer_r == '0);

  // write-enable latch
  always_ff @(posedge clock) begin
    if (rst) begin
      wen_r <= 1'b0;
    end else if (new_cmd && !busy_r) begin
      if (cmd_r == eeprom_pkg::enable_writes_cmd) begin
        wen_r <= 1'b1;
      end
      if (cmd_r == eeprom_pkg::disable_writes_cmd) begin
        wen_r <= 1'b0;
      end
    end
  end

  // self-timed programming cycle; select toggles do not touch it
  // timer ignores select
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b0;
      timer_r <= '0;
      job_r <= eeprom_pkg::cmd_none;
      job_addr_r <= 4'h0;
      job_data_r <= 16'h0000;
    end else if (prog_start) begin
      busy_r <= 1'b1;
      timer_r <= TW'(PROGRAM_CYCLES - 1);
      job_r <= cmd_r;
      job_addr_r <= addr_r;
      job_data_r <= data_r;
    end else if (busy_r) begin
      if (timer_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        timer_r <= timer_r - TW'(1);
      end
    end
  end

  // array update at the end of programming
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
        mem_r[i] <= eeprom_pkg::ERASED_WORD;
      end
    end else if (prog_end) begin
      for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
        unique case (job_r)
          eeprom_pkg::write_cmd:
            if (job_addr_r == 4'(i)) mem_r[i] <= job_data_r;
          eeprom_pkg::fill_all_cmd: mem_r[i] <= job_data_r;
          eeprom_pkg::erase_cmd:
            if (job_addr_r == 4'(i)) mem_r[i] <= eeprom_pkg::ERASED_WORD;
          eeprom_pkg::clear_all_cmd: mem_r[i] <= eeprom_pkg::ERASED_WORD;
          default: mem_r[i] <= mem_r[i];
        endcase
      end
    end
  end

  // status display; a new programming start wins over a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= 1'b0;
    end else if (prog_start) begin
      status_r <= 1'b1;
    end else if (clr_s2 != clr_seen_r && !busy_r) begin
      // start bit after ready releases output
      status_r <= 1'b0;
    end
  end

  // low while busy, high when ready
  // no shift clock needed for status
  assign link.serial_out = status_r ? ~busy_r : out_sh_r[16];
  assign link.serial_out_oe = link.select &
                              (status_r | (phase_r == ph_read));
  assign busy = busy_r;
endmodule

// ---- src/eeprom_master.sv ----
`timescale 1ns/1ps
// master end: makes the shift clock by division and runs one
// instruction per request, polling status after programming
module eeprom_master #(
  parameter int HALF_CYCLES = eeprom_pkg::SHIFT_HALF_CYCLES,
  parameter int GAP_CYCLES = eeprom_pkg::DESELECT_CYCLES,
  parameter int SETTLE_CYCLES = eeprom_pkg::STATUS_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eeprom_pkg::cmd_e cmd,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  output logic rsp_valid,
  output logic [15:0] rdata,
  eeprom_if.host link
);
  typedef enum {m_idle, m_gap, m_shift, m_read, m_rest, m_poll} mstate_e;

  mstate_e state_r;
  logic [24:0] frame_r; // start, opcode, address, data
  logic [4:0] last_r; // index of last frame bit
  logic [4:0] nbit_r; // bit counter
  logic [7:0] wait_r; // gap and settle counter
  logic [7:0] half_r; // shift clock divider
  logic sk_r, sel_r;
  logic is_read_r, is_prog_r;
  logic do_s1, do_s2; // output line synchroniser
  logic tick; // half period elapsed
  logic [1:0] op, sub;

  // opcode and subcode for the request
  always_comb begin
    op = eeprom_pkg::OP_EXTENDED;
    sub = 2'h0;
    unique case (cmd)
      eeprom_pkg::read_cmd: op = eeprom_pkg::OP_READ;
      eeprom_pkg::write_cmd: op = eeprom_pkg::OP_WRITE;
      eeprom_pkg::erase_cmd: op = eeprom_pkg::OP_ERASE;
      eeprom_pkg::enable_writes_cmd: sub = eeprom_pkg::SUB_ENABLE;
      eeprom_pkg::fill_all_cmd: sub = eeprom_pkg::SUB_FILL;
      eeprom_pkg::clear_all_cmd: sub = eeprom_pkg::SUB_CLEAR;
      default: sub = eeprom_pkg::SUB_DISABLE;
    endcase
  end

  // divider runs only while bits are moving
  always_ff @(posedge clock) begin
    if (rst || !(state_r == m_shift || state_r == m_read)) begin
      half_r <= 8'h00;
    end else if (tick) begin
      half_r <= 8'h00;
    end else begin
      half_r <= half_r + 8'h01;
    end
  end
  assign tick = (half_r == 8'(HALF_CYCLES - 1));

  // output line synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      do_s1 <= 1'b1;
      do_s2 <= 1'b1;
    end else begin
      do_s1 <= link.serial_line;
      do_s2 <= do_s1;
    end
  end

  // transfer sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= m_idle;
      frame_r <= 25'h0000000;
      last_r <= 5'h00;
      nbit_r <= 5'h00;
      wait_r <= 8'h00;
      sk_r <= 1'b0;
      sel_r <= 1'b0;
      is_read_r <= 1'b0;
      is_prog_r <= 1'b0;
      rsp_valid <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_r)
        m_idle: if (cmd_valid) begin
          // data only for write and fill, msb first
          frame_r <= {1'b1, op, sub, addr, wdata};
          last_r <= (cmd == eeprom_pkg::write_cmd ||
                     cmd == eeprom_pkg::fill_all_cmd) ?
                    eeprom_pkg::LONG_FRAME_LAST :
                    eeprom_pkg::SHORT_FRAME_LAST;
          is_read_r <= (cmd == eeprom_pkg::read_cmd);
          is_prog_r <= (cmd == eeprom_pkg::write_cmd ||
                        cmd == eeprom_pkg::fill_all_cmd ||
                        cmd == eeprom_pkg::erase_cmd ||
                        cmd == eeprom_pkg::clear_all_cmd);
          wait_r <= 8'(GAP_CYCLES - 1);
          state_r <= m_gap;
        end
        m_gap: begin
          if (wait_r == 8'h00) begin
            sel_r <= 1'b1;
            nbit_r <= 5'h00;
            state_r <= m_shift;
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        m_shift: if (tick) begin
          sk_r <= ~sk_r;
          if (sk_r) begin
            frame_r <= {frame_r[23:0], 1'b0};
            nbit_r <= nbit_r + 5'h01;
            if (nbit_r == last_r) begin
              nbit_r <= 5'h00;
              if (is_read_r) begin
                state_r <= m_read;
              end else begin
                sel_r <= 1'b0;
                wait_r <= 8'(GAP_CYCLES - 1);
                state_r <= is_prog_r ? m_rest : m_idle;
                rsp_valid <= ~is_prog_r;
              end
            end
          end
        end
        m_read: if (tick) begin
          sk_r <= ~sk_r;
          if (sk_r) begin
            rdata <= {rdata[14:0], do_s2};
            nbit_r <= nbit_r + 5'h01;
            if (nbit_r == {1'b0, eeprom_pkg::DATA_LAST}) begin
              sel_r <= 1'b0;
              rsp_valid <= 1'b1;
              state_r <= m_idle;
            end
          end
        end
        m_rest: begin
          if (wait_r == 8'h00) begin
            sel_r <= 1'b1;
            wait_r <= 8'(SETTLE_CYCLES - 1);
            state_r <= m_poll;
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        m_poll: begin
          if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
          end else if (do_s2) begin
            sel_r <= 1'b0;
            rsp_valid <= 1'b1;
            state_r <= m_idle;
          end
        end
      endcase
    end
  end

  assign cmd_ready = (state_r == m_idle);
  assign link.shift_clock = sk_r;
  assign link.select = sel_r;
  assign link.serial_in = (state_r == m_shift) ? frame_r[24] : 1'b0;
endmodule

// ---- testbench/eeprom_link_monitor.sv ----
`timescale 1ns/1ps
// link watcher: sampled on the local clock, which is far faster
// than the divided shift clock, so every link edge is seen
module eeprom_link_monitor #(
  parameter int PROGRAM_CYCLES = 50,
  parameter int GAP_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic busy,
  input wire logic shift_clock,
  input wire logic select,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_line
);
  logic [7:0] gap_cnt_r; // cycles with select low
  logic [15:0] busy_cnt_r; // cycles of the current busy stretch
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // deselect gap length, saturating
  always_ff @(posedge clock) begin
    if (rst || select) begin
      gap_cnt_r <= 8'h00;
    end else if (gap_cnt_r != 8'hff) begin
      gap_cnt_r <= gap_cnt_r + 8'h01;
    end
  end
  // busy stretch length
  always_ff @(posedge clock) begin
    if (rst || !busy) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
  end
  sequence busy_shown;
    serial_out_oe && !serial_out;
  endsequence
  sequence ready_shown;
    serial_out_oe && serial_line;
  endsequence
  // a one clocked in on a rising shift edge while selected
  sequence start_clocked;
    $rose(shift_clock) && select && serial_in;
  endsequence
  output_off_a: assert property (!select |-> !serial_out_oe)
    else $error("output driven while deselected");
  poll_busy_a: assert property
    ($rose(select) && busy |-> ##[0:2] busy_shown)
    else $error("busy not shown on poll");
  poll_ready_a: assert property
    ($fell(busy) && select |-> ##[0:3] ready_shown)
    else $error("ready not shown after programming");
  prog_start_a: assert property ($rose(busy) |-> !select)
    else $error("programming began while selected");
  // two clocks of slack either way for the hand-over into the timer
  prog_len_a: assert property ($fell(busy) |->
    busy_cnt_r >= PROGRAM_CYCLES - 2 && busy_cnt_r <= PROGRAM_CYCLES + 2)
    else $error("programming time wrong");
  sk_still_a: assert property (!select || busy |-> !shift_clock)
    else $error("shift clock runs outside a frame");
  din_stable_a: assert property
    ($rose(shift_clock) |-> $stable(serial_in))
    else $error("serial input moved at sampling edge");
  // one cycle of slack: the counter starts a clock after select drops
  gap_min_a: assert property
    ($rose(select) |-> gap_cnt_r >= GAP_CYCLES - 1)
    else $error("deselect gap too short");
  // the clear crosses into the local clock, so allow a few clocks
  ready_clear_a: assert property
    (start_clocked ##0 ready_shown |-> ##[1:6] !serial_out_oe)
    else $error("ready status not cleared by start bit");
endmodule

// ---- testbench/serial_eeprom_command_port_tb_top.sv ----
`timescale 1ns/1ps
// drives the master's request side and reads back through the device
module serial_eeprom_command_port_tb_top;
  localparam int PROG = 50; // shortened programming time
  localparam int LIMIT = 40000; // cycle ceiling for the whole run
  logic clock;
  logic rst;
  logic cmd_valid;
  logic cmd_ready;
  eeprom_pkg::cmd_e cmd;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic rsp_valid;
  logic [15:0] rdata;
  logic busy;
  int bad_count;
  int n_compared;
  int cycles;
  eeprom_if lnk();
  eeprom_device #(.PROGRAM_CYCLES(PROG)) u_eeprom_device (
    .clock(clock), .rst(rst), .busy(busy), .link(lnk.dev));
  eeprom_master u_eeprom_master (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .addr(addr), .wdata(wdata),
    .rsp_valid(rsp_valid), .rdata(rdata), .link(lnk.host));
  eeprom_link_monitor #(
    .PROGRAM_CYCLES(PROG),
    .GAP_CYCLES(eeprom_pkg::DESELECT_CYCLES)
  ) u_mon (
    .clock(clock), .rst(rst), .busy(busy),
    .shift_clock(lnk.shift_clock), .select(lnk.select),
    .serial_in(lnk.serial_in), .serial_out(lnk.serial_out),
    .serial_out_oe(lnk.serial_out_oe), .serial_line(lnk.serial_line));
  // 10 mhz local clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction: offer, wait for take, then for completion
  task automatic run(input eeprom_pkg::cmd_e c, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge clock);
    #1;
    cmd = c;
    addr = a;
    wdata = d;
    cmd_valid = 1'b1;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    do @(posedge clock); while (rsp_valid !== 1'b1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    run(eeprom_pkg::read_cmd, a, 16'h0000);
    check(rdata, exp);
  endtask
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = eeprom_pkg::cmd_none;
    addr = 4'h0;
    wdata = 16'h0000;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    // reads work while writes are off; writes are refused
    rd(4'h3, 16'hffff);
    run(eeprom_pkg::write_cmd, 4'h3, 16'h5a5a);
    rd(4'h3, 16'hffff);
    $display("test write_protect done");
    // enable, then word writes to address 3 and to the top address f
    run(eeprom_pkg::enable_writes_cmd, 4'h0, 16'h0000);
    run(eeprom_pkg::write_cmd, 4'h3, 16'ha5c3);
    run(eeprom_pkg::write_cmd, 4'hf, 16'h0001);
    rd(4'h3, 16'ha5c3);
    rd(4'hf, 16'h0001);
    rd(4'h0, 16'hffff);
    $display("test word_write done");
    // one pattern into every word
    run(eeprom_pkg::fill_all_cmd, 4'h0, 16'h1234);
    for (int i = 0; i < 16; i += 5) begin
      rd(i[3:0], 16'h1234);
    end
    $display("test fill_all done");
    // erase one word, neighbour untouched
    run(eeprom_pkg::erase_cmd, 4'h9, 16'h0000);
    rd(4'h9, 16'hffff);
    rd(4'h8, 16'h1234);
    // erase everything
    run(eeprom_pkg::clear_all_cmd, 4'h0, 16'h0000);
    rd(4'h4, 16'hffff);
    rd(4'hf, 16'hffff);
    $display("test erase done");
    // disable, later write ignored
    run(eeprom_pkg::disable_writes_cmd, 4'h0, 16'h0000);
    run(eeprom_pkg::write_cmd, 4'h2, 16'h0f0f);
    rd(4'h2, 16'hffff);
    $display("test disable done");
    end_of_test();
  end
endmodule
